// *** hw/ntpt_chain.sv ***
/*
  nand chain: stage k nands input k with the previous stage, stage 0 with a one.
  assumes inputs are already synchronised; purely combinational.
*/
`timescale 1ns/1ps
`default_nettype none
module ntpt_chain
  import ntpt_pkg::*;
#(
  parameter int unsigned LEN = NTPT_CHAIN_LEN
) (
  input wire logic [LEN-1:0] i_in,
  output logic o_last
);
  if (LEN < 1) begin : g_len_chk
    $error("chain length must be at least one");
  end

  logic [LEN:0] stage;
  assign stage[0] = NTPT_CHAIN_SEED;
  genvar k;
  generate
    for (k = 0; k < LEN; k++) begin : g_stage
      assign stage[k+1] = ~(i_in[k] & stage[k]);
    end
  endgenerate
  assign o_last = stage[LEN];
endmodule
`default_nettype wire

// *** hw/ntpt_pkg.sv ***
/*
  package for the nand chain pin test block: strap code, chain ranks, pin carriers.
  assumes a single clock domain; no software registers.
*/
package ntpt_pkg;

  localparam int unsigned NTPT_CHAIN_LEN = 17;
  localparam int unsigned NTPT_STRAP_W = 5;
  localparam logic [4:0] NTPT_MODE_NAND = 5'h04;
  localparam logic NTPT_CHAIN_SEED = 1'b1;
  localparam int unsigned NTPT_SYNC_DEPTH = 2;

  // chain ranks, rank 0 is the first stage
  localparam int unsigned NTPT_RK_STATUS_LIGHT_2 = 0;
  localparam int unsigned NTPT_RK_STATUS_LIGHT_1 = 1;
  localparam int unsigned NTPT_RK_TXD0 = 2;
  localparam int unsigned NTPT_RK_TXC = 6;
  localparam int unsigned NTPT_RK_TX_CTL = 7;
  localparam int unsigned NTPT_RK_RXD3 = 8;
  localparam int unsigned NTPT_RK_RX_CTL = 12;
  localparam int unsigned NTPT_RK_RXC = 13;
  localparam int unsigned NTPT_RK_IRQ_WAKE = 14;
  localparam int unsigned NTPT_RK_MDC = 15;
  localparam int unsigned NTPT_RK_MDIO = 16;

  typedef struct packed {
    logic [4:0] mode;
    logic ref_clock_out_strap;
  } ntpt_straps_t;

  typedef struct packed {
    logic status_light_2;
    logic status_light_1_wake_out;
    logic [3:0] txd;
    logic txc;
    logic tx_ctl;
    logic [3:0] rxd;
    logic rx_ctl;
    logic rxc;
    logic irq_wake_out_pin;
    logic mdc;
    logic mdio;
  } ntpt_pins_t;

  typedef struct packed {
    logic o;
    logic oe;
  } ntpt_outpin_t;

endpackage

// *** hw/ntpt_top.sv ***
/*
  nand chain pin test: strap decode, pin synchronisers, chain and output drive.
  assumes straps are stable around reset release and the board sets the
  clock-out strap; pins arrive from outside the clock domain.
  straps are taken at the third enabled edge after reset release; the output
  pin shows a pin change three enabled edges after the pin moves.
  the chain result is registered, so the output pin never shows a glitch.
  all chain pins stay inputs, so o_pin_oe is held low.
*/
`timescale 1ns/1ps
`default_nettype none
module ntpt_top
  import ntpt_pkg::*;
#(
  parameter int unsigned CHAIN_LEN = NTPT_CHAIN_LEN
) (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_ce,
  input wire ntpt_straps_t i_straps,
  input wire ntpt_pins_t i_pins,
  output ntpt_outpin_t o_ref_clock_tree_out,
  output logic o_test_mode,
  output logic [CHAIN_LEN-1:0] o_pin_oe
);
  // =====================================================
  // parameter checks
  if (CHAIN_LEN != NTPT_CHAIN_LEN) begin : g_len_chk
    $error("pin map serves exactly seventeen chain ranks");
  end
  if (NTPT_SYNC_DEPTH != 2) begin : g_sync_chk
    $error("strap fill count expects a two-stage synchroniser");
  end
  if (NTPT_STRAP_W != $bits(NTPT_MODE_NAND)) begin : g_strap_chk
    $error("strap width disagrees with the mode code");
  end
  if (NTPT_RK_STATUS_LIGHT_2 != 0 || NTPT_RK_MDIO != CHAIN_LEN - 1) begin : g_end_chk
    $error("chain must start and end at the first and last rank");
  end
  if (NTPT_RK_TXD0 + 3 >= NTPT_RK_TXC) begin : g_txd_chk
    $error("transmit data ranks overlap the transmit clock");
  end
  if (NTPT_RK_RXD3 + 3 >= NTPT_RK_RX_CTL) begin : g_rxd_chk
    $error("receive data ranks overlap the receive control");
  end

  // =====================================================
  // rank map
  logic [CHAIN_LEN-1:0] pin_rank;

  // rank order, rank 0 first
  always_comb begin
    pin_rank = '0;
    // status and wake pins
    pin_rank[NTPT_RK_STATUS_LIGHT_2] = i_pins.status_light_2;
    pin_rank[NTPT_RK_STATUS_LIGHT_1] = i_pins.status_light_1_wake_out;
    // transmit group
    pin_rank[NTPT_RK_TXD0 + 0] = i_pins.txd[0];
    pin_rank[NTPT_RK_TXD0 + 1] = i_pins.txd[1];
    pin_rank[NTPT_RK_TXD0 + 2] = i_pins.txd[2];
    pin_rank[NTPT_RK_TXD0 + 3] = i_pins.txd[3];
    pin_rank[NTPT_RK_TXC] = i_pins.txc;
    pin_rank[NTPT_RK_TX_CTL] = i_pins.tx_ctl;
    // receive group
    pin_rank[NTPT_RK_RXD3 + 0] = i_pins.rxd[3];
    pin_rank[NTPT_RK_RXD3 + 1] = i_pins.rxd[2];
    pin_rank[NTPT_RK_RXD3 + 2] = i_pins.rxd[1];
    pin_rank[NTPT_RK_RXD3 + 3] = i_pins.rxd[0];
    pin_rank[NTPT_RK_RX_CTL] = i_pins.rx_ctl;
    pin_rank[NTPT_RK_RXC] = i_pins.rxc;
    // interrupt and management pins
    pin_rank[NTPT_RK_IRQ_WAKE] = i_pins.irq_wake_out_pin;
    pin_rank[NTPT_RK_MDC] = i_pins.mdc;
    pin_rank[NTPT_RK_MDIO] = i_pins.mdio;
  end

  // =====================================================
  // strap synchroniser
  // straps reset to a code other than the test mode, so the output pin
  // stays undriven until the straps have been taken
  ntpt_straps_t strap_s1_r;
  ntpt_straps_t strap_s2_r;

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      strap_s1_r <= '0;
      strap_s2_r <= '0;
    end else if (i_ce) begin
      strap_s1_r <= i_straps;
      strap_s2_r <= strap_s1_r;
    end
  end

  // =====================================================
  // pin synchroniser
  logic [CHAIN_LEN-1:0] pin_s1_r;
  logic [CHAIN_LEN-1:0] pin_s2_r;

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end else if (i_ce) begin
      pin_s1_r <= pin_rank;
      pin_s2_r <= pin_s1_r;
    end
  end

  // =====================================================
  // strap latch: sample once after reset release
  // edge 1 after release fills the first stage, edge 2 the second and
  // moves to sample, edge 3 takes the straps; later strap changes are
  // ignored until the next reset
  typedef enum logic [1:0] {
    ST_FILL,
    ST_SAMPLE,
    ST_HOLD
  } ntpt_state_t;

  ntpt_state_t state_r;
  logic [1:0] fill_r;

  // counts enabled edges until the strap synchroniser holds a fresh value
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      state_r <= ST_FILL;
      fill_r <= '0;
    end else if (i_ce) begin
      unique case (state_r)
        ST_FILL: begin
          fill_r <= fill_r + 2'h1;
          if (fill_r == 2'(NTPT_SYNC_DEPTH - 1)) begin
            state_r <= ST_SAMPLE;
          end
        end
        ST_SAMPLE: state_r <= ST_HOLD;
        ST_HOLD: state_r <= ST_HOLD;
        // an illegal code restarts the fill
        default: state_r <= ST_FILL;
      endcase
    end
  end

  // =====================================================
  // mode latch
  logic strap_take;
  logic mode_match;
  logic test_mode_r;
  logic clk_out_en_r;

  assign strap_take = i_ce && (state_r == ST_SAMPLE);
  assign mode_match = (strap_s2_r.mode == NTPT_MODE_NAND);

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      test_mode_r <= 1'b0;
      clk_out_en_r <= 1'b0;
    end else if (strap_take) begin
      test_mode_r <= mode_match;
      clk_out_en_r <= strap_s2_r.ref_clock_out_strap;
    end
  end

  // =====================================================
  // chain
  // with lower ranks low and higher ranks high, the output pin follows the
  // toggled pin at even ranks and shows its inverse at odd ranks:
  //   0 status_light_2: follows
  //   1 status_light_1_wake_out: inverted
  //   2 txd0: follows
  //   3 txd1: inverted
  //   4 txd2: follows
  //   5 txd3: inverted
  //   6 txc: follows
  //   7 tx_ctl: inverted
  //   8 rxd3: follows
  //   9 rxd2: inverted
  //   10 rxd1: follows
  //   11 rxd0: inverted
  //   12 rx_ctl: follows
  //   13 rxc: inverted
  //   14 irq_wake_out_pin: follows
  //   15 mdc: inverted
  //   16 mdio: follows
  logic chain_last;

  ntpt_chain #(
    .LEN(CHAIN_LEN)
  ) u_chain (
    .i_in(pin_s2_r),
    .o_last(chain_last)
  );

  // =====================================================
  // output drive
  // the final inversion sits in the output register
  logic tree_out_r;

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      tree_out_r <= 1'b0;
    end else if (i_ce) begin
      tree_out_r <= ~chain_last;
    end
  end

  assign o_ref_clock_tree_out.o = tree_out_r;
  // the pin is driven only in test mode with the clock-out strap set
  assign o_ref_clock_tree_out.oe = test_mode_r & clk_out_en_r;
  assign o_test_mode = test_mode_r;
  // every chain pin is an input in this mode
  assign o_pin_oe = '0;
endmodule
`default_nettype wire

// *** testbench/ntpt_board.sv ***
/* board tester model: one-pin toggle bias.
   assumes the rank order of the chain; ranks are mapped onto the pin fields. */
`timescale 1ns/1ps
`default_nettype none
module ntpt_board
  import ntpt_pkg::*;
(
  input wire logic i_mclk,
  input wire logic [4:0] i_rank,
  input wire logic i_lvl,
  output var ntpt_pins_t o_pins
);
  // rank k at bit k: lower ranks low, higher high
  logic [16:0] bias;
  assign bias = (17'h1ffff << (i_rank + 5'h1)) | (17'(i_lvl) << i_rank);
  // ranks onto the pin fields; txd is carried msb first, rxd in rank order
  always_ff @(posedge i_mclk) begin
    o_pins <= {bias[0], bias[1], bias[5], bias[4], bias[3], bias[2], bias[6], bias[7],
      bias[8], bias[9], bias[10], bias[11], bias[12], bias[13], bias[14], bias[15], bias[16]};
  end
endmodule
`default_nettype wire

// *** testbench/ntpt_chk.sv ***
/* port checker for ntpt_top.
   assumes i_ce high. */
`timescale 1ns/1ps
`default_nettype none
module ntpt_chk
  import ntpt_pkg::*;
#(
  parameter int unsigned CHAIN_LEN = 17
) (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire ntpt_straps_t i_straps,
  input wire ntpt_pins_t i_pins,
  input wire ntpt_outpin_t o_ref_clock_tree_out,
  input wire logic o_test_mode,
  input wire logic [CHAIN_LEN-1:0] o_pin_oe
);
  logic [2:0] cnt_r;
  ntpt_straps_t cap_r;
  logic o;
  assign o = o_ref_clock_tree_out.o;
  always_ff @(posedge i_mclk) begin
    cnt_r <= !i_reset_n ? 3'h0 : cnt_r + 3'(cnt_r != 3'h7);
  end
  always_ff @(posedge i_mclk) begin
    if (cnt_r == 3'h0) cap_r <= i_straps;
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  sequence settled;
    cnt_r == 3'h7;
  endsequence
  // ========
  // checks
  mode_sel_a: assert property (cnt_r == 3'h4 |->
    o_test_mode == (cap_r.mode == NTPT_MODE_NAND)) else $error("mode");
  mode_hold_a: assert property (settled |-> $stable(o_test_mode)) else $error("hold");
  oe_drive_a: assert property (settled |-> o_ref_clock_tree_out.oe ==
    (cap_r.mode == NTPT_MODE_NAND && cap_r.ref_clock_out_strap)) else $error("oe");
  all_low_a: assert property ((settled and $past(i_pins, 3) == '0) |->
    !o) else $error("lo");
  all_high_a: assert property ((settled and $past(i_pins, 3) == '1) |->
    o) else $error("hi");
  last_pin_a: assert property ((settled and ($past(i_pins, 3) & 17'h1fffe) == '0) |->
    o == $past(i_pins.mdio, 3)) else $error("pol");
  pins_in_a: assert property (o_pin_oe == '0) else $error("pin");
  rst_clr_a: assert property (disable iff (1'b0) !i_reset_n |=>
    !o_test_mode && !o_ref_clock_tree_out.oe) else $error("rst");
endmodule
bind ntpt_top ntpt_chk #(.CHAIN_LEN(CHAIN_LEN)) i_ntpt_chk (.*);
`default_nettype wire

// *** testbench/testbench.sv ***
/* bench for ntpt_top: straps and one-pin toggles.
   assumes ntpt_board biases pins. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module testbench;
  import ntpt_pkg::*;
  logic i_mclk = 1'b0, rst_n = 1'b0, lvl = 1'b0, mode;
  ntpt_straps_t straps = '0;
  logic [4:0] rank = '0;
  ntpt_pins_t pins;
  ntpt_outpin_t out;
  int fails = 0, tests_run = 0;
  initial forever #20 i_mclk = ~i_mclk;
  ntpt_board i_ntpt_board (.i_mclk, .i_rank(rank), .i_lvl(lvl), .o_pins(pins));
  ntpt_top i_ntpt_top (.i_mclk, .i_reset_n(rst_n), .i_ce(1'b1), .i_straps(straps),
    .i_pins(pins), .o_ref_clock_tree_out(out), .o_test_mode(mode), .o_pin_oe());
  task automatic t_strap(input logic [4:0] m, input logic c);
    @(posedge i_mclk) rst_n <= 1'b0;
    straps <= '{m, c};
    repeat (5) @(posedge i_mclk);
    rst_n <= 1'b1;
    repeat (6) @(posedge i_mclk);
    straps <= '1;
    repeat (3) @(posedge i_mclk);
    #1;
    `CHK("mode", m == NTPT_MODE_NAND, mode)
    `CHK("oe", m == NTPT_MODE_NAND && c, out.oe)
    $display("strap %h done", m);
  endtask
  task automatic t_pins();
    for (int k = 0; k < 17; k++) begin
      for (int v = 0; v < 2; v++) begin
        @(posedge i_mclk);
        rank <= 5'(k);
        lvl <= 1'(v);
        repeat (6) @(posedge i_mclk);
        #1;
        `CHK("tree", 1'(v ^ k), out.o)
      end
    end
    $display("pins done");
  endtask
  task automatic finish_test();
    $display("checks %0d bad %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge i_mclk);
    fails++;
    finish_test();
  end
  initial begin
    t_strap(5'h03, 1'b1);
    t_strap(5'h04, 1'b0);
    t_strap(5'h04, 1'b1);
    t_pins();
    finish_test();
  end
endmodule
`default_nettype wire
